/* rtl/plw_pkg.sv */
// Constants, register map and types of the program loop watchdog
package plw_pkg;

   // Register port geometry
   localparam int          PLW_ADDR_W        = 16;
   localparam int          PLW_DATA_W        = 8;

   // Register offsets
   localparam logic [15:0] PLW_MODE_OFFS     = 16'hff48;
   localparam logic [15:0] PLW_RESTART_OFFS  = 16'hff49;
   localparam logic [15:0] PLW_CAUSE_OFFS    = 16'hff4a;

   // Mode register layout and reset value
   localparam logic [7:0]  PLW_MODE_RESET    = 8'h67;
   localparam logic [2:0]  PLW_MODE_FIXED    = 3'h3;
   localparam int          PLW_MODE_FIX_LSB  = 5;
   localparam int          PLW_SEL_HI_BIT    = 4;
   localparam int          PLW_SEL_LO_BIT    = 3;
   localparam int          PLW_IVL_MSB       = 2;
   localparam logic [2:0]  PLW_IVL_MAX       = 3'h7;

   // Restart register key and the value it reads back
   localparam logic [7:0]  PLW_RESTART_KEY   = 8'hac;
   localparam logic [7:0]  PLW_RESTART_READ  = 8'h9a;

   // Reset cause register layout
   localparam int          PLW_WDRF_BIT      = 4;

   // Interval exponents: 2^(base + code) source clocks
   localparam int          PLW_SLOW_EXP_MIN  = 11;
   localparam int          PLW_SYS_EXP_MIN   = 13;
   localparam int          PLW_CNT_W         = 21;

   // Length of the internal reset request, in system clocks
   localparam logic [2:0]  PLW_RST_PULSE_CYC = 3'h4;

   typedef enum logic [1:0] {
      PLW_SRC_SLOW,
      PLW_SRC_SYS,
      PLW_SRC_OFF
   } plw_src_t;

   typedef enum logic {
      PLW_RUN,
      PLW_FIRE
   } plw_state_t;

endpackage : plw_pkg

/* rtl/plw_slow_tick.sv */
// Synchroniser and rising edge detector for the slow oscillator clock
`timescale 1ns/10ps
module plw_slow_tick (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic slow_osc_clk,
   output logic      slow_tick
);

   logic [2:0] sync_r;
   logic [2:0] sync_nxt;

   // Stage 0 feeds only stage 1; the edge is seen between 1 and 2
   always_comb begin
      sync_nxt = {sync_r[1:0], slow_osc_clk};
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // All ones: a pin already high at release gives no false edge
         sync_r <= 3'h7;
      end else begin
         sync_r <= sync_nxt;
      end
   end

   assign slow_tick = sync_r[1] & ~sync_r[2];

endmodule : plw_slow_tick

/* rtl/plw_watchdog.sv */
// Program loop watchdog: mode/restart registers, counter, reset request
//
// How it works
// - Count expiry without restart raises the internal reset request.
// - A watchdog reset sets bit 4 of the reset cause register.
// - Slow clock intervals are 2^11 to 2^18 cycles, one per code.
// - System clock intervals are 2^13 to 2^20 cycles, one per code.
// - Unstoppable option always counts on the slow oscillator clock.
// - Stoppable option: software picks system, slow or none; slow at reset.
// - After reset counting starts at once on 2^18 slow clocks.
// - Unstoppable option: only the interval may change, once per reset.
// - Stoppable option: clock and interval change together, once.
// - Unstoppable option offers no way to halt the count.
// - Stoppable option halts the count when the stopped code is chosen.
// - Unstoppable option keeps the slow oscillator running.
// - System clock source is gated when stopped, standby or stabilising.
// - Stoppable option: slow source gated in standby, or if stopped before stop on sys CPU.
// - Mode register reads freely but takes only one write per reset.
// - Mode register resets to 67h.
// - Writing ACh to the restart register clears the count and restarts.
// - Any other restart value raises the internal reset request unless the count is stopped.
// - A second mode write raises reset unless the first one stopped it.
// - Select bits 4:3: 00 slow, 01 system, 1x stopped.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
module plw_watchdog
   import plw_pkg::*;
#(
   parameter int SLOW_EXP_MIN = PLW_SLOW_EXP_MIN,
   parameter int SYS_EXP_MIN  = PLW_SYS_EXP_MIN
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  por_rst,
   input  wire logic [PLW_ADDR_W-1:0] addr,
   input  wire logic [PLW_DATA_W-1:0] wdata,
   input  wire logic                  wr_stb,
   input  wire logic                  rd_stb,
   output logic      [PLW_DATA_W-1:0] rdata,
   input  wire logic                  slow_osc_clk,
   input  wire logic                  slow_osc_lock_opt,
   input  wire logic                  slow_osc_sw_stop,
   input  wire logic                  cpu_on_sys_clk,
   input  wire logic                  cpu_standby,
   input  wire logic                  sys_clk_stopped,
   input  wire logic                  osc_stabilizing,
   output logic                       slow_osc_keep_on,
   output logic                       internal_reset_req,
   output logic                       watchdog_reset_flag
);

   // The counter must hold the longest interval of either source
   if (SLOW_EXP_MIN < 1 || SYS_EXP_MIN < 1 ||
       SLOW_EXP_MIN + 7 > PLW_CNT_W || SYS_EXP_MIN + 7 > PLW_CNT_W) begin : g_bad_exp
      $error("plw_watchdog: interval exponents do not fit the counter");
   end

   // Terminal count of an interval: 2^(base + code) - 1
   function automatic logic [PLW_CNT_W-1:0] plw_top(
      input plw_src_t   src,
      input logic [2:0] code
   );
      int exp_v;
      exp_v = (src == PLW_SRC_SYS) ? SYS_EXP_MIN : SLOW_EXP_MIN;
      exp_v = exp_v + int'(code);
      return (PLW_CNT_W'(1) << exp_v) - PLW_CNT_W'(1);
   endfunction : plw_top

   // Decode of the two clock select bits
   function automatic plw_src_t plw_src(input logic [1:0] sel);
      plw_src_t s;
      s = PLW_SRC_SLOW;
      if (sel[1]) begin
         s = PLW_SRC_OFF;
      end else if (sel[0]) begin
         s = PLW_SRC_SYS;
      end
      return s;
   endfunction : plw_src

   // ------------------------------------------------------------------
   // Option strap, caught once in the first cycle after release
   // ------------------------------------------------------------------
   logic opt_taken_r;
   logic opt_taken_nxt;
   logic opt_locked_r;
   logic opt_locked_nxt;

   always_comb begin
      opt_taken_nxt  = 1'b1;
      opt_locked_nxt = opt_taken_r ? opt_locked_r : slow_osc_lock_opt;
   end

   // Locked until known: the safer reading of the strap
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         opt_taken_r  <= 1'b0;
         opt_locked_r <= 1'b1;
      end else begin
         opt_taken_r  <= opt_taken_nxt;
         opt_locked_r <= opt_locked_nxt;
      end
   end

   // Locked option: oscillator may drop out only while reset is held
   assign slow_osc_keep_on = opt_locked_r & ~rst;

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   logic mode_wr;
   logic restart_wr;
   logic cause_rd;

   assign mode_wr    = wr_stb && (addr == PLW_MODE_OFFS);
   assign restart_wr = wr_stb && (addr == PLW_RESTART_OFFS);
   assign cause_rd   = rd_stb && (addr == PLW_CAUSE_OFFS);

   // ------------------------------------------------------------------
   // Mode register, written once per reset
   // ------------------------------------------------------------------
   logic [1:0]     sel_r;
   logic [1:0]     sel_nxt;
   logic [2:0]     ivl_r;
   logic [2:0]     ivl_nxt;
   logic           mode_written_r;
   logic           mode_written_nxt;
   logic [7:0]     mode_view;
   plw_src_t       src;
   logic           wd_stopped;

   assign src        = plw_src(sel_r);
   assign wd_stopped = (src == PLW_SRC_OFF);

   always_comb begin
      sel_nxt          = sel_r;
      ivl_nxt          = ivl_r;
      mode_written_nxt = mode_written_r;
      if (mode_wr && !mode_written_r) begin
         mode_written_nxt = 1'b1;
         ivl_nxt          = wdata[PLW_IVL_MSB:0];
         if (!opt_locked_r) begin
            // Clock and interval are taken together
            sel_nxt = wdata[PLW_SEL_HI_BIT:PLW_SEL_LO_BIT];
         end
         // Locked option ignores the select bits, so slow stays chosen
         // and no code can stop the count
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Slow clock, longest interval
         sel_r          <= PLW_MODE_RESET[PLW_SEL_HI_BIT:PLW_SEL_LO_BIT];
         ivl_r          <= PLW_MODE_RESET[PLW_IVL_MSB:0];
         mode_written_r <= 1'b0;
      end else begin
         sel_r          <= sel_nxt;
         ivl_r          <= ivl_nxt;
         mode_written_r <= mode_written_nxt;
      end
   end

   assign mode_view = {PLW_MODE_FIXED, sel_r, ivl_r};

   // ------------------------------------------------------------------
   // Count clock selection and gating
   // ------------------------------------------------------------------
   logic slow_tick;
   logic sys_gate;
   logic slow_gate;
   logic tick;

   plw_slow_tick u_slow_tick (
      .clk          (clk),
      .rst          (rst),
      .slow_osc_clk (slow_osc_clk),
      .slow_tick    (slow_tick)
   );

   assign sys_gate = sys_clk_stopped | cpu_standby |
                     osc_stabilizing;

   // With the locked option the slow source keeps counting through
   // standby, so software must restart it from a wake-up source
   assign slow_gate = ~opt_locked_r &
                      (cpu_standby |
                       (cpu_on_sys_clk & slow_osc_sw_stop));

   always_comb begin
      case (src)
         PLW_SRC_SLOW: tick = slow_tick & ~slow_gate;
         PLW_SRC_SYS:  tick = ~sys_gate;
         PLW_SRC_OFF:  tick = 1'b0;
         default:      tick = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------
   // Faults that request the internal reset
   // ------------------------------------------------------------------
   logic [PLW_CNT_W-1:0] cnt_r;
   logic [PLW_CNT_W-1:0] cnt_nxt;
   logic [PLW_CNT_W-1:0] cnt_top;
   logic                 expire;
   logic                 key_ok;
   logic                 bad_key;
   logic                 second_mode_wr;
   logic                 fault;
   logic                 cnt_clear;

   assign cnt_top = plw_top(src, ivl_r);
   assign expire  = tick && (cnt_r == cnt_top);
   assign key_ok  = restart_wr && (wdata == PLW_RESTART_KEY);

   // A stopped watchdog forgives bad keys and repeated mode writes
   assign bad_key        = restart_wr && (wdata != PLW_RESTART_KEY) &&
                           !wd_stopped;
   assign second_mode_wr = mode_wr && mode_written_r && !wd_stopped;
   assign fault          = expire | bad_key | second_mode_wr;

   // The first mode write restarts the count as well
   assign cnt_clear = key_ok | (mode_wr && !mode_written_r);

   always_comb begin
      cnt_nxt = cnt_r;
      if (cnt_clear || wd_stopped) begin
         cnt_nxt = '0;
      end else if (expire) begin
         cnt_nxt = '0;
      end else if (tick) begin
         cnt_nxt = cnt_r + PLW_CNT_W'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Reset request sequencer
   // ------------------------------------------------------------------
   plw_state_t state_r;
   plw_state_t state_nxt;
   logic [2:0] pulse_r;
   logic [2:0] pulse_nxt;
   logic       req_r;
   logic       req_nxt;
   logic       fire;

   always_comb begin
      state_nxt = state_r;
      pulse_nxt = pulse_r;
      req_nxt   = 1'b0;
      fire      = 1'b0;
      case (state_r)
         PLW_RUN: begin
            if (fault) begin
               state_nxt = PLW_FIRE;
               pulse_nxt = PLW_RST_PULSE_CYC - 3'h1;
               req_nxt   = 1'b1;
               fire      = 1'b1;
            end
         end
         PLW_FIRE: begin
            // Held for a fixed width; the system reset normally ends it
            if (pulse_r == 3'h0) begin
               state_nxt = PLW_RUN;
            end else begin
               pulse_nxt = pulse_r - 3'h1;
               req_nxt   = 1'b1;
            end
         end
         default: begin
            state_nxt = PLW_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= PLW_RUN;
         pulse_r <= 3'h0;
         req_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pulse_r <= pulse_nxt;
         req_r   <= req_nxt;
      end
   end

   assign internal_reset_req = req_r;

   // ------------------------------------------------------------------
   // Reset cause flag: kept through the reset that it reports
   // ------------------------------------------------------------------
   logic wdrf_r;
   logic wdrf_nxt;

   always_comb begin
      wdrf_nxt = wdrf_r;
      if (cause_rd) begin
         wdrf_nxt = 1'b0;
      end
      // A new watchdog event beats a clearing read
      if (fire) begin
         wdrf_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge por_rst) begin
      if (por_rst) begin
         wdrf_r <= 1'b0;
      end else begin
         wdrf_r <= wdrf_nxt;
      end
   end

   assign watchdog_reset_flag = wdrf_r;

   // ------------------------------------------------------------------
   // Read data, valid only in the cycle after the strobe
   // ------------------------------------------------------------------
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   always_comb begin
      rdata_nxt = 8'h00;
      if (rd_stb) begin
         case (addr)
            PLW_MODE_OFFS:    rdata_nxt = mode_view;
            PLW_RESTART_OFFS: rdata_nxt = PLW_RESTART_READ;
            PLW_CAUSE_OFFS:   rdata_nxt[PLW_WDRF_BIT] = wdrf_r;
            default:          rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata = rdata_r;

endmodule : plw_watchdog

/* dv/plw_properties.sv */
// Port assertions for the program loop watchdog
`timescale 1ns/10ps
module plw_checker
   import plw_pkg::*;
#(
   parameter int SLOW_EXP_MIN = PLW_SLOW_EXP_MIN,
   parameter int SYS_EXP_MIN  = PLW_SYS_EXP_MIN
) (
   input wire logic                  clk,
   input wire logic                  rst,
   input wire logic [PLW_ADDR_W-1:0] addr,
   input wire logic [PLW_DATA_W-1:0] wdata,
   input wire logic                  wr_stb,
   input wire logic                  rd_stb,
   input wire logic [PLW_DATA_W-1:0] rdata,
   input wire logic                  slow_osc_lock_opt,
   input wire logic                  slow_osc_keep_on,
   input wire logic                  internal_reset_req,
   input wire logic                  watchdog_reset_flag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic wr_mode, mode_wr_r, mode_wr_nxt, stop_r, stop_nxt;

   // A first write that stops the count forgives later faults
   assign wr_mode = wr_stb && addr == PLW_MODE_OFFS;
   always_comb begin
      mode_wr_nxt = mode_wr_r | wr_mode;
      stop_nxt    = stop_r | (wr_mode & ~mode_wr_r & wdata[PLW_SEL_HI_BIT]
                    & ~slow_osc_lock_opt);
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_wr_r <= 1'b0;
         stop_r    <= 1'b0;
      end else begin
         mode_wr_r <= mode_wr_nxt;
         stop_r    <= stop_nxt;
      end
   end

   sequence s_pulse;
      internal_reset_req [*4] ##1 !internal_reset_req;
   endsequence
   sequence s_fault;
      ##[1:5] internal_reset_req;
   endsequence
   sequence s_up;
      !rst [*3];
   endsequence

   a_pulse_len: assert property (
      $rose(internal_reset_req) |-> s_pulse)
      else $error("reset request pulse has the wrong length");
   a_flag_set: assert property (
      $rose(internal_reset_req) |-> ##[0:1] watchdog_reset_flag)
      else $error("watchdog flag not set by a fault");
   a_flag_hold: assert property (
      watchdog_reset_flag && !rd_stb && !$past(rd_stb)
      |=> watchdog_reset_flag)
      else $error("watchdog flag lost without a read");
   a_rd_idle: assert property (
      !rd_stb |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_mode_fixed: assert property (
      rd_stb && addr == PLW_MODE_OFFS |=> rdata[7:5] == PLW_MODE_FIXED)
      else $error("mode register fixed bits wrong");
   a_lock_sel: assert property (
      rd_stb && addr == PLW_MODE_OFFS && slow_osc_lock_opt
      |=> rdata[4:3] == 2'b00)
      else $error("clock select not held on slow clock");
   a_restart_rd: assert property (
      rd_stb && addr == PLW_RESTART_OFFS |=> rdata == PLW_RESTART_READ)
      else $error("restart register read value wrong");
   a_bad_key: assert property (
      wr_stb && addr == PLW_RESTART_OFFS && wdata != PLW_RESTART_KEY &&
      !stop_r |-> s_fault)
      else $error("wrong restart key gave no reset");
   a_second_wr: assert property (
      wr_mode && mode_wr_r && !stop_r |-> s_fault)
      else $error("second mode write gave no reset");
   a_keep_on: assert property (
      s_up |-> slow_osc_keep_on == slow_osc_lock_opt)
      else $error("oscillator keep-on does not follow the option");
endmodule : plw_checker

/* dv/plw_cpu_model.sv */
// Register bus master standing in for the CPU software
`timescale 1ns/10ps
module plw_cpu_model (
   input  wire logic        clk,
   output logic      [15:0] addr,
   output logic      [7:0]  wdata,
   output logic             wr_stb,
   output logic             rd_stb,
   input  wire logic [7:0]  rdata
);
   initial begin
      addr   = 16'h0000;
      wdata  = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end

   // Whole-byte stores only: the bus offers no bit-set access
   task automatic wr(input logic [15:0] a, input logic [7:0] dv);
      @(posedge clk);
      addr   <= a;
      wdata  <= dv;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [7:0] dv);
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      dv = rdata;
   endtask : rd
endmodule : plw_cpu_model

/* dv/plw_tb.sv */
// Testbench for the program loop watchdog
`timescale 1ns/10ps
module testbench;
   import plw_pkg::*;

   localparam int SLOW_B = 2;
   localparam int SYS_B  = 3;

   logic        clk, rst, por_rst, slow_clk, lock, keep_on, req, flag;
   logic        wr_stb, rd_stb;
   logic [4:0]  g;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata, d;
   int          n_fail, num_checks, slow_n, n, t0;

   plw_watchdog #(.SLOW_EXP_MIN(SLOW_B), .SYS_EXP_MIN(SYS_B)) dut_u (
      .clk(clk), .rst(rst), .por_rst(por_rst), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .slow_osc_clk(slow_clk), .slow_osc_lock_opt(lock),
      .slow_osc_sw_stop(g[4]), .cpu_on_sys_clk(g[3]), .cpu_standby(g[0]),
      .sys_clk_stopped(g[1]), .osc_stabilizing(g[2]),
      .slow_osc_keep_on(keep_on), .internal_reset_req(req),
      .watchdog_reset_flag(flag));

   plw_cpu_model cpu_u (.clk(clk), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Odd half period keeps the slow clock out of step with clk
   initial begin
      slow_clk = 1'b0;
      #7;
      forever #33 slow_clk = ~slow_clk;
   end
   always @(posedge slow_clk) slow_n++;

   task automatic check(input logic [31:0] seen, exp, input int tol);
      num_checks++;
      if ((^seen === 1'bx) || seen + tol < exp || seen > exp + tol) begin
         n_fail++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out;
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out

   // Counts clocks until the reset request shows; with must set, a hang ends the run
   task automatic wait_req(input int lim, input bit must);
      n = 0;
      while (req !== 1'b1 && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (must && n >= lim) begin
         n_fail++;
         close_out();
      end
   endtask : wait_req

   task automatic do_reset(input logic lk);
      @(posedge clk);
      rst  <= 1'b1;
      lock <= lk;
      g    <= 5'h00;
      repeat (16) @(posedge clk);
      rst     <= 1'b0;
      por_rst <= 1'b0;
      t0 = slow_n;
      repeat (3) @(posedge clk);
      #1 check(keep_on, lk, 0);
   endtask : do_reset

   task automatic t_defaults;
      cpu_u.rd(PLW_MODE_OFFS, d);
      check(d, PLW_MODE_RESET, 0);
      wait_req(20000, 1);
      check(slow_n - t0, 1 << (SLOW_B + 7), 2);
      check(flag, 1, 0);
      cpu_u.rd(PLW_CAUSE_OFFS, d);
      check(d[PLW_WDRF_BIT], 1, 0);
      $display("defaults done");
   endtask : t_defaults

   task automatic t_slow;
      for (int c = 0; c < 8; c++) begin
         do_reset(1'b1);
         cpu_u.wr(PLW_MODE_OFFS, {3'h3, 2'b10, c[2:0]});
         t0 = slow_n;
         cpu_u.rd(PLW_MODE_OFFS, d);
         check(d, {3'h3, 2'b00, c[2:0]}, 0);
         wait_req(20000, 1);
         check(slow_n - t0, 1 << (SLOW_B + c), 2);
      end
      $display("slow intervals done");
   endtask : t_slow

   task automatic t_sys;
      for (int c = 0; c < 8; c++) begin
         do_reset(1'b0);
         cpu_u.wr(PLW_MODE_OFFS, {3'h3, 2'b01, c[2:0]});
         wait_req(2000, 1);
         check(n, 1 << (SYS_B + c), 2);
      end
      $display("system intervals done");
   endtask : t_sys

   task automatic t_restart;
      do_reset(1'b0);
      cpu_u.wr(PLW_MODE_OFFS, 8'h69);
      repeat (4) begin
         wait_req(10, 0);
         check(n, 10, 0);
         cpu_u.wr(PLW_RESTART_OFFS, PLW_RESTART_KEY);
      end
      cpu_u.wr(PLW_RESTART_OFFS, 8'h5a);
      wait_req(4, 1);
      check(n, 1, 1);
      // The first high cycle was already seen by wait_req
      n = 1;
      while (req === 1'b1 && n < 9) begin
         @(posedge clk);
         #1;
         n++;
      end
      check(n, PLW_RST_PULSE_CYC, 0);
      do_reset(1'b0);
      cpu_u.wr(PLW_MODE_OFFS, 8'h6f);
      cpu_u.wr(PLW_MODE_OFFS, 8'h60);
      wait_req(4, 1);
      check(n, 1, 1);
      cpu_u.rd(PLW_MODE_OFFS, d);
      check(d, 8'h6f, 0);
      $display("restart and rewrite done");
   endtask : t_restart

   task automatic t_stop;
      do_reset(1'b0);
      cpu_u.wr(PLW_MODE_OFFS, 8'h70);
      cpu_u.wr(PLW_RESTART_OFFS, 8'h00);
      cpu_u.wr(PLW_MODE_OFFS, 8'h68);
      wait_req(4000, 0);
      check(n, 4000, 0);
      $display("stop done");
   endtask : t_stop

   task automatic t_gate;
      for (int i = 0; i < 3; i++) begin
         do_reset(1'b0);
         cpu_u.wr(PLW_MODE_OFFS, 8'h68);
         @(posedge clk);
         g <= 5'h01 << i;
         wait_req(100, 0);
         check(n, 100, 0);
         @(posedge clk);
         g <= 5'h00;
         wait_req(20, 1);
         check(n, 7, 3);
      end
      do_reset(1'b0);
      cpu_u.wr(PLW_MODE_OFFS, 8'h60);
      @(posedge clk);
      g <= 5'h18;
      wait_req(300, 0);
      check(n, 300, 0);
      @(posedge clk);
      g <= 5'h01;
      wait_req(300, 0);
      check(n, 300, 0);
      @(posedge clk);
      g <= 5'h00;
      wait_req(100, 1);
      // Four slow ticks of about 6.6 clocks; one may precede the gate
      check(n, 21, 8);
      $display("clock gating done");
   endtask : t_gate

   initial begin
      rst     = 1'b1;
      por_rst = 1'b1;
      lock    = 1'b1;
      g       = 5'h00;
      do_reset(1'b1);
      t_defaults();
      t_slow();
      t_sys();
      t_restart();
      t_stop();
      t_gate();
      close_out();
   end
endmodule : testbench

bind plw_watchdog plw_checker #(.SLOW_EXP_MIN(SLOW_EXP_MIN),
   .SYS_EXP_MIN(SYS_EXP_MIN)) chk_u (.clk(clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
   .slow_osc_lock_opt(slow_osc_lock_opt),
   .slow_osc_keep_on(slow_osc_keep_on),
   .internal_reset_req(internal_reset_req),
   .watchdog_reset_flag(watchdog_reset_flag));
